// *** hw/mem_access_pkg.sv ***
// Constants for table read, return stack and data memory banking
package mem_access_pkg;
  // Special-purpose register locations
  localparam logic [7:0] ADDR_IND0 = 8'h00;
  localparam logic [7:0] ADDR_MP0 = 8'h01;
  localparam logic [7:0] ADDR_IND1 = 8'h02;
  localparam logic [7:0] ADDR_MP1 = 8'h03;
  localparam logic [7:0] ADDR_BANK = 8'h04;
  localparam logic [7:0] ADDR_TPL = 8'h07;
  localparam logic [7:0] ADDR_THB = 8'h08;
  localparam logic [7:0] ADDR_TPH = 8'h1F;
  // Data memory decode limits
  localparam logic [7:0] SPECIAL_LAST = 8'h2F;
  localparam logic [7:0] GENERAL_FIRST = 8'h40;
  localparam logic [7:0] DISP_FIRST = 8'h80;
  localparam logic [7:0] DISP_LAST = 8'hA7;
  localparam logic [4:0] BANK_GENERAL = 5'h00;
  localparam logic [4:0] BANK_DISPLAY = 5'h0F;
  // Bank select bit that supplies ROM address bit 13
  localparam int ROM_BANK_BIT = 5;
  // Forced page for the last-page table read
  localparam logic [5:0] LAST_PAGE = 6'h3F;
  // Reset values
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [2:0] SP_RESET = 3'h0;
  // Access target kinds
  localparam logic [1:0] SEL_NONE = 2'h0;
  localparam logic [1:0] SEL_SPECIAL = 2'h1;
  localparam logic [1:0] SEL_GENERAL = 2'h2;
  localparam logic [1:0] SEL_DISPLAY = 2'h3;
endpackage

// *** hw/mem_access.sv ***
// Table read, return stack and banked data memory of the core
`timescale 1ns/10ps
module mem_access #(
  parameter int DEPTH = 8,
  parameter int DISP_BYTES = 40
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [7:0] dm_addr,
  input wire logic dm_rd,
  input wire logic dm_wr,
  input wire logic [7:0] dm_wdata,
  input wire logic dm_bset,
  input wire logic dm_bclr,
  input wire logic [2:0] dm_bit,
  output logic [7:0] dm_rdata_q,
  input wire logic tbl_any_req,
  input wire logic tbl_last_req,
  input wire logic [7:0] tbl_dest,
  input wire logic [15:0] rom_data,
  output logic [13:0] rom_addr_q,
  output logic tbl_busy_q,
  input wire logic [12:0] pc_in,
  input wire logic call_req,
  input wire logic jump_req,
  input wire logic ret_req,
  input wire logic int_req,
  output logic int_ack_q,
  output logic stack_full_q,
  output logic [12:0] ret_pc_q,
  output logic rom_bank_q,
  output logic [DISP_BYTES*8-1:0] disp_dots_q
);
  typedef enum logic {T_IDLE, T_FETCH} tbl_state_e;

  // Resolves an access address to a target kind and an effective address
  function automatic logic [9:0] mem_sel(input logic [7:0] a, input logic [7:0] p0,
                                         input logic [7:0] p1, input logic [4:0] bank);
    logic [7:0] ea;
    logic ind;
    logic via1;
    ind = (a == mem_access_pkg::ADDR_IND0) || (a == mem_access_pkg::ADDR_IND1);
    via1 = (a == mem_access_pkg::ADDR_IND1);
    ea = (a == mem_access_pkg::ADDR_IND0) ? p0 : (via1 ? p1 : a);
    if (ind && (ea == mem_access_pkg::ADDR_IND0 || ea == mem_access_pkg::ADDR_IND1))
      mem_sel = {mem_access_pkg::SEL_NONE, ea};
    else if (ea <= mem_access_pkg::SPECIAL_LAST)
      mem_sel = {mem_access_pkg::SEL_SPECIAL, ea};
    else if (via1 && bank == mem_access_pkg::BANK_DISPLAY
             && ea >= mem_access_pkg::DISP_FIRST && ea <= mem_access_pkg::DISP_LAST)
      mem_sel = {mem_access_pkg::SEL_DISPLAY, ea};
    else if (bank == mem_access_pkg::BANK_GENERAL && ea >= mem_access_pkg::GENERAL_FIRST)
      mem_sel = {mem_access_pkg::SEL_GENERAL, ea};
    else
      mem_sel = {mem_access_pkg::SEL_NONE, ea};
  endfunction

  logic [7:0] mp0_q, mp0_d, mp1_q, mp1_d, bank_q, bank_d;
  logic [7:0] tpl_q, tpl_d, tph_q, tph_d, thb_q, thb_d;
  logic [7:0] gp_mem [0:255-8'h40];
  logic [7:0] dest_q, dest_d;
  tbl_state_e tst_q, tst_d;
  logic [13:0] rom_addr_d;
  logic busy_d;
  logic [9:0] rsel, wsel;
  logic [7:0] cur, wval, wa, rd_d;
  logic we;
  logic [5:0] didx_r, didx_w;
  logic [13:0] stk [0:DEPTH-1];
  logic [2:0] sp_q, sp_d, top;
  logic [3:0] fill_q, fill_d;
  logic full_d, ack_d, bank_d13, push, pop;
  logic [12:0] ret_d;

  // Read-side decode and current value of the addressed location
  always_comb
  begin
    rsel = mem_sel(dm_addr, mp0_q, mp1_q, bank_q[4:0]);
    didx_r = 6'(rsel[7:0] - mem_access_pkg::DISP_FIRST);
    cur = 8'h00;
    case (rsel[9:8])
      mem_access_pkg::SEL_SPECIAL:
        case (rsel[7:0])
          mem_access_pkg::ADDR_MP0: cur = mp0_q;
          mem_access_pkg::ADDR_MP1: cur = mp1_q;
          mem_access_pkg::ADDR_BANK: cur = bank_q;
          mem_access_pkg::ADDR_TPL: cur = tpl_q;
          mem_access_pkg::ADDR_THB: cur = thb_q;
          mem_access_pkg::ADDR_TPH: cur = tph_q;
          default: cur = 8'h00;
        endcase
      mem_access_pkg::SEL_GENERAL: cur = gp_mem[8'(rsel[7:0] - mem_access_pkg::GENERAL_FIRST)];
      mem_access_pkg::SEL_DISPLAY: cur = disp_dots_q[{didx_r, 3'b000} +: 8];
      default: cur = 8'h00;
    endcase
    rd_d = dm_rd ? cur : dm_rdata_q;
  end

  // Single write port; the table read's second cycle owns it
  always_comb
  begin
    if (tst_q == T_FETCH)
    begin
      wa = dest_q;
      wval = rom_data[7:0];
      we = 1'b1;
    end
    else
    begin
      wa = dm_addr;
      we = dm_wr | dm_bset | dm_bclr;
      if (dm_bset)
        wval = cur | (8'h01 << dm_bit);
      else if (dm_bclr)
        wval = cur & ~(8'h01 << dm_bit);
      else
        wval = dm_wdata;
    end
    wsel = mem_sel(wa, mp0_q, mp1_q, bank_q[4:0]);
    didx_w = 6'(wsel[7:0] - mem_access_pkg::DISP_FIRST);
  end

  // Special registers and table sequencer next values
  always_comb
  begin
    mp0_d = mp0_q;
    mp1_d = mp1_q;
    bank_d = bank_q;
    tpl_d = tpl_q;
    tph_d = tph_q;
    thb_d = thb_q;
    dest_d = dest_q;
    tst_d = tst_q;
    rom_addr_d = rom_addr_q;
    busy_d = 1'b0;
    if (we && wsel[9:8] == mem_access_pkg::SEL_SPECIAL)
      case (wsel[7:0])
        mem_access_pkg::ADDR_MP0: mp0_d = wval;
        mem_access_pkg::ADDR_MP1: mp1_d = wval;
        mem_access_pkg::ADDR_BANK: bank_d = wval;
        mem_access_pkg::ADDR_TPL: tpl_d = wval;
        mem_access_pkg::ADDR_TPH: tph_d = wval;
        default: ;
      endcase
    case (tst_q)
      T_IDLE:
        if (tbl_any_req || tbl_last_req)
        begin
          tst_d = T_FETCH;
          busy_d = 1'b1;
          dest_d = tbl_dest;
          if (tbl_last_req)
            rom_addr_d = {mem_access_pkg::LAST_PAGE, tpl_q};
          else
            rom_addr_d = {tph_q[5:0], tpl_q};
        end
      T_FETCH:
      begin
        thb_d = rom_data[15:8];
        tst_d = T_IDLE;
      end
      default: tst_d = T_IDLE;
    endcase
  end

  // Register state of the data side and the table sequencer
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      mp0_q <= mem_access_pkg::REG_RESET;
      mp1_q <= mem_access_pkg::REG_RESET;
      bank_q <= mem_access_pkg::REG_RESET;
      tpl_q <= mem_access_pkg::REG_RESET;
      tph_q <= mem_access_pkg::REG_RESET;
      thb_q <= mem_access_pkg::REG_RESET;
      dest_q <= mem_access_pkg::REG_RESET;
      dm_rdata_q <= mem_access_pkg::REG_RESET;
      rom_addr_q <= 14'h0000;
      tbl_busy_q <= 1'b0;
      tst_q <= T_IDLE;
      disp_dots_q <= '0;
    end
    else
    begin
      mp0_q <= mp0_d;
      mp1_q <= mp1_d;
      bank_q <= bank_d;
      tpl_q <= tpl_d;
      tph_q <= tph_d;
      thb_q <= thb_d;
      dest_q <= dest_d;
      dm_rdata_q <= rd_d;
      rom_addr_q <= rom_addr_d;
      tbl_busy_q <= busy_d;
      tst_q <= tst_d;
      if (we && wsel[9:8] == mem_access_pkg::SEL_DISPLAY)
        disp_dots_q[{didx_w, 3'b000} +: 8] <= wval;
    end
  end

  // General memory holds no reset
  always_ff @(posedge clk)
  begin
    if (we && wsel[9:8] == mem_access_pkg::SEL_GENERAL)
      gp_mem[8'(wsel[7:0] - mem_access_pkg::GENERAL_FIRST)] <= wval;
  end

  // Stack control: return wins over call and acknowledge, which waits out a jump
  // Fill count, not the index, tells empty from full once the index has wrapped
  always_comb
  begin
    top = sp_q - 3'h1;
    pop = ret_req && (fill_q != 4'h0);
    ack_d = int_req && !stack_full_q && !call_req && !ret_req && !jump_req
            && !int_ack_q;
    push = (call_req || ack_d) && !ret_req;
    sp_d = sp_q;
    fill_d = fill_q;
    full_d = stack_full_q;
    ret_d = ret_pc_q;
    bank_d13 = rom_bank_q;
    if (pop)
    begin
      sp_d = top;
      fill_d = fill_q - 4'h1;
      full_d = 1'b0;
      ret_d = stk[top][12:0];
      bank_d13 = stk[top][13];
    end
    else if (push)
    begin
      sp_d = sp_q + 3'h1;
      fill_d = stack_full_q ? fill_q : fill_q + 4'h1;
      full_d = (fill_d == 4'(DEPTH));
      bank_d13 = call_req ? bank_q[mem_access_pkg::ROM_BANK_BIT] : 1'b0;
    end
    else if (jump_req)
      bank_d13 = bank_q[mem_access_pkg::ROM_BANK_BIT];
  end

  // Stack entries and pointer; nothing here is software visible
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      sp_q <= mem_access_pkg::SP_RESET;
      fill_q <= 4'h0;
      stack_full_q <= 1'b0;
      int_ack_q <= 1'b0;
      ret_pc_q <= 13'h0000;
      rom_bank_q <= 1'b0;
    end
    else
    begin
      sp_q <= sp_d;
      fill_q <= fill_d;
      stack_full_q <= full_d;
      int_ack_q <= ack_d;
      ret_pc_q <= ret_d;
      rom_bank_q <= bank_d13;
      if (push)
        stk[sp_q] <= {rom_bank_q, pc_in};
    end
  end

  // Checks
  chk_tbl_two_cycle: assert property (@(posedge clk) disable iff (!nrst)
    (tst_q == T_IDLE && (tbl_any_req || tbl_last_req)) |=> tbl_busy_q ##1 !tbl_busy_q)
    else $error("table read not two cycles");
  chk_any_bank_addr: assert property (@(posedge clk) disable iff (!nrst)
    (tst_q == T_IDLE && tbl_any_req && !tbl_last_req)
    |=> rom_addr_q == {$past(tph_q[5:0]), $past(tpl_q)})
    else $error("any-bank address wrong");
  chk_last_page_addr: assert property (@(posedge clk) disable iff (!nrst)
    (tst_q == T_IDLE && tbl_last_req)
    |=> rom_addr_q == {mem_access_pkg::LAST_PAGE, $past(tpl_q)})
    else $error("last-page address wrong");
  chk_high_byte_load: assert property (@(posedge clk) disable iff (!nrst)
    tst_q == T_FETCH |=> thb_q == $past(rom_data[15:8]))
    else $error("high byte not loaded");
  chk_high_ro: assert property (@(posedge clk) disable iff (!nrst)
    tst_q == T_IDLE |=> $stable(thb_q))
    else $error("high byte changed outside table read");
  chk_full_no_ack: assert property (@(posedge clk) disable iff (!nrst)
    stack_full_q |=> !int_ack_q)
    else $error("acknowledge on full stack");
  chk_ret_restore: assert property (@(posedge clk) disable iff (!nrst)
    pop |=> ret_pc_q == $past(stk[top][12:0]) && rom_bank_q == $past(stk[top][13]))
    else $error("return value wrong");
  chk_full_wrap: assert property (@(posedge clk) disable iff (!nrst)
    (push && stack_full_q) |=> stack_full_q && sp_q == 3'($past(sp_q) + 3'h1))
    else $error("overflow push wrong");
  chk_disp_ptr0: assert property (@(posedge clk) disable iff (!nrst)
    (tst_q == T_IDLE && dm_addr == mem_access_pkg::ADDR_IND0) |=> $stable(disp_dots_q))
    else $error("first pointer reached display");
  chk_bank_latch: assert property (@(posedge clk) disable iff (!nrst)
    ((jump_req || call_req) && !ret_req)
    |=> rom_bank_q == $past(bank_q[mem_access_pkg::ROM_BANK_BIT]))
    else $error("bank bit not latched");
  cov_table_read: cover property (@(posedge clk) disable iff (!nrst)
    tst_q == T_FETCH ##1 tst_q == T_IDLE);
  cov_stack_full: cover property (@(posedge clk) disable iff (!nrst)
    int_req && stack_full_q ##1 pop);
  cov_disp_write: cover property (@(posedge clk) disable iff (!nrst)
    we && wsel[9:8] == mem_access_pkg::SEL_DISPLAY);
endmodule // mem_access

// *** dv/table_rom_model.sv ***
// Program ROM model answering table fetches of the memory access block
`timescale 1ns/10ps
module table_rom_model (
  input wire logic [13:0] addr,
  output logic [15:0] data
);
  // Word mixes both address bytes so a wrong page or offset shows up
  assign data = {addr[7:0] ^ 8'hC3, 2'h1, addr[13:8]};
endmodule // table_rom_model

// *** dv/mem_access_tb_top.sv ***
// Self-checking bench for table reads, return stack and banked data memory
`timescale 1ns/10ps
module mem_access_tb_top;
  logic clk, nrst, dm_rd, dm_wr, dm_bset, dm_bclr, tbl_any_req, tbl_last_req;
  logic call_req, jump_req, ret_req, int_req, tbl_busy_q, int_ack_q, stack_full_q, rom_bank_q;
  logic [7:0] dm_addr, dm_wdata, tbl_dest, dm_rdata_q, v, g, d;
  logic [2:0] dm_bit;
  logic [15:0] rom_data;
  logic [13:0] rom_addr_q;
  logic [12:0] pc_in, ret_pc_q;
  logic [319:0] disp_dots_q;
  logic [12:0] pcs [0:8];
  logic [7:0] rw_addr [0:4];
  int mismatches = 0;
  int cmp_count = 0;
  int cycles = 0;
  int seed, b, k, acks;

  mem_access mem_access_inst (.clk, .nrst, .dm_addr, .dm_rd, .dm_wr, .dm_wdata, .dm_bset,
    .dm_bclr, .dm_bit, .dm_rdata_q, .tbl_any_req, .tbl_last_req, .tbl_dest, .rom_data,
    .rom_addr_q, .tbl_busy_q, .pc_in, .call_req, .jump_req, .ret_req, .int_req, .int_ack_q,
    .stack_full_q, .ret_pc_q, .rom_bank_q, .disp_dots_q);
  table_rom_model table_rom_model_inst (.addr(rom_addr_q), .data(rom_data));

  // Clock and hang guard
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      mismatches = mismatches + 1;
      close_out();
    end
  end

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] x);
    @(posedge clk);
    dm_addr <= a;
    dm_wdata <= x;
    dm_wr <= 1'b1;
    @(posedge clk);
    dm_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] x);
    @(posedge clk);
    dm_addr <= a;
    dm_rd <= 1'b1;
    @(posedge clk);
    dm_rd <= 1'b0;
    #1 x = dm_rdata_q;
  endtask
  task automatic bop(input logic [7:0] a, input int n, input logic set);
    @(posedge clk);
    dm_addr <= a;
    dm_bit <= 3'(n);
    dm_bset <= set;
    dm_bclr <= ~set;
    @(posedge clk);
    {dm_bset, dm_bclr} <= 2'h0;
  endtask
  // Sequencer pulse: 0 call, 1 return, 2 jump
  task automatic pulse(input int kind, input logic [12:0] p);
    @(posedge clk);
    pc_in <= p;
    call_req <= (kind == 0);
    ret_req <= (kind == 1);
    jump_req <= (kind == 2);
    @(posedge clk);
    {call_req, ret_req, jump_req} <= 3'h0;
    #1;
  endtask
  task automatic tbl(input logic last, input logic [7:0] lo, input logic [7:0] hi,
    input logic [7:0] dst);
    logic [13:0] a;
    logic [15:0] w;
    a = {last ? mem_access_pkg::LAST_PAGE : hi[5:0], lo};
    w = {lo ^ 8'hC3, 2'h1, a[13:8]};
    wr(mem_access_pkg::ADDR_TPL, lo);
    wr(mem_access_pkg::ADDR_TPH, hi);
    @(posedge clk);
    tbl_dest <= dst;
    tbl_any_req <= ~last;
    tbl_last_req <= last;
    @(posedge clk);
    {tbl_any_req, tbl_last_req} <= 2'h0;
    #1 chk("rom_addr", a, rom_addr_q);
    chk("busy", 1, tbl_busy_q);
    @(posedge clk);
    #1 chk("busy_end", 0, tbl_busy_q);
    rd(dst, v);
    chk("dest", w[7:0], v);
    rd(mem_access_pkg::ADDR_THB, v);
    chk("high_byte", w[15:8], v);
  endtask
  task automatic close_out;
    $display("Checks %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    seed = $urandom(32'hD15E0AF5);
    {nrst, dm_rd, dm_wr, dm_bset, dm_bclr, tbl_any_req, tbl_last_req} = 7'h0;
    {call_req, jump_req, ret_req, int_req} = 4'h0;
    {dm_addr, dm_wdata, tbl_dest, dm_bit, pc_in} = '0;
    rw_addr = '{mem_access_pkg::ADDR_MP0, mem_access_pkg::ADDR_MP1, mem_access_pkg::ADDR_TPL,
      mem_access_pkg::ADDR_TPH, mem_access_pkg::ADDR_BANK};
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    rd(mem_access_pkg::ADDR_TPH, v);
    chk("tph_reset", 0, v);
    chk("full_reset", 0, stack_full_q);
    // Pointer and bank registers hold what was written; unused places read zero
    for (k = 0; k < 5; k++)
    begin
      d = 8'($urandom);
      wr(rw_addr[k], d);
      rd(rw_addr[k], v);
      chk("reg_rw", d, v);
    end
    wr(mem_access_pkg::ADDR_BANK, 8'h00);
    wr(8'h0F, 8'hFF);
    rd(8'h0F, v);
    chk("unused", 0, v);
    wr(mem_access_pkg::ADDR_MP0, mem_access_pkg::ADDR_IND1);
    rd(mem_access_pkg::ADDR_IND0, v);
    chk("ind_ind", 0, v);
    // General memory: byte, bit and indirect access, both range ends first
    for (k = 0; k < 6; k++)
    begin
      g = (k == 0) ? 8'h40 : (k == 1) ? 8'hFF : 8'h40 + 8'($urandom_range(191));
      d = 8'($urandom);
      b = $urandom_range(7);
      wr(g, d);
      bop(g, b, 1'b1);
      rd(g, v);
      chk("bit_set", d | (8'h1 << b), v);
      bop(g, b, 1'b0);
      wr(mem_access_pkg::ADDR_MP1, g);
      rd(mem_access_pkg::ADDR_IND1, v);
      chk("bit_clr", d & ~(8'h1 << b), v);
      wr(mem_access_pkg::ADDR_MP0, g);
      wr(mem_access_pkg::ADDR_IND0, d ^ 8'hFF);
      rd(g, v);
      chk("ind_wr", d ^ 8'hFF, v);
    end
    // Table reads of both kinds, then a write that must not land
    for (k = 0; k < 4; k++)
      tbl(k[0], 8'($urandom), 8'($urandom), 8'h40 + 8'($urandom_range(191)));
    tbl(1'b1, 8'h5A, 8'h00, 8'h80);
    wr(mem_access_pkg::ADDR_THB, 8'h66);
    rd(mem_access_pkg::ADDR_THB, v);
    chk("thb_ro", 8'h5A ^ 8'hC3, v);
    // Display bank: second pointer lights dots, first pointer is shut out
    wr(mem_access_pkg::ADDR_BANK, {3'h0, mem_access_pkg::BANK_DISPLAY});
    for (k = 0; k < 40; k += 13)
    begin
      d = 8'($urandom);
      wr(mem_access_pkg::ADDR_MP1, mem_access_pkg::DISP_FIRST + 8'(k));
      wr(mem_access_pkg::ADDR_IND1, d);
      wr(mem_access_pkg::ADDR_MP0, mem_access_pkg::DISP_FIRST + 8'(k));
      wr(mem_access_pkg::ADDR_IND0, d ^ 8'hFF);
      @(posedge clk);
      #1 chk("dots", d, disp_dots_q[8*k +: 8]);
    end
    // ROM bank latch travels through the stack
    wr(mem_access_pkg::ADDR_BANK, 8'h20);
    pulse(2, 13'h0);
    chk("bank_latch", 1, rom_bank_q);
    wr(mem_access_pkg::ADDR_BANK, 8'h00);
    pulse(0, 13'h1ABC);
    pulse(1, 13'h0);
    chk("ret_pc", 13'h1ABC, ret_pc_q);
    chk("ret_bank", 1, rom_bank_q);
    // Nine calls: oldest lost, eight come back newest first
    for (k = 0; k < 9; k++)
    begin
      pcs[k] = 13'($urandom);
      pulse(0, pcs[k]);
    end
    chk("full", 1, stack_full_q);
    for (k = 8; k > 0; k--)
    begin
      pulse(1, 13'h0);
      chk("pop", pcs[k], ret_pc_q);
    end
    pulse(1, 13'h0);
    chk("pop_empty", pcs[1], ret_pc_q);
    // Full stack holds back the acknowledge until a return
    for (k = 0; k < 8; k++)
      pulse(0, 13'(k));
    @(posedge clk);
    int_req <= 1'b1;
    acks = 0;
    repeat (5)
    begin
      @(posedge clk);
      #1 acks += int'(int_ack_q === 1'b1);
    end
    chk("ack_held", 0, 16'(acks));
    pulse(1, 13'h0);
    chk("ret_full", 13'h7, ret_pc_q);
    repeat (4)
    begin
      @(posedge clk);
      #1 acks += int'(int_ack_q === 1'b1);
    end
    chk("ack_after", 1, 16'(acks));
    @(posedge clk);
    int_req <= 1'b0;
    close_out();
  end
endmodule // mem_access_tb_top
